// file: src/ccv_pkg.sv
// Package for the charger current and voltage configuration bank.
// Assumes a byte-wide register port behind a two-wire serial target.
package ccv_pkg;

	// Two-wire target address, 7 bits
	localparam logic [6:0] CCV_TARGET_ADDR = 7'h6b;

	// Register indices on the serial bus
	localparam logic [7:0] CCV_IDX_BOOST_FAST = 8'h02;
	localparam logic [7:0] CCV_IDX_PRE_TERM   = 8'h03;
	localparam logic [7:0] CCV_IDX_VOLT_TOP   = 8'h04;

	// Power-on values of the three registers
	localparam logic [7:0] CCV_POR_BOOST_FAST = 8'ha2;
	localparam logic [7:0] CCV_POR_PRE_TERM   = 8'h22;
	localparam logic [7:0] CCV_POR_VOLT_TOP   = 8'h58;

	// Field positions
	localparam int CCV_BOOST_CURRENT_LIMIT_BIT = 7;
	localparam int CCV_FULL_ON_BIT   = 6;
	localparam int CCV_FAST_LSB      = 0;
	localparam int CCV_PRE_LSB       = 4;
	localparam int CCV_TERM_LSB      = 0;
	localparam int CCV_VOLT_LSB      = 3;
	localparam int CCV_TOP_LSB       = 1;
	localparam int CCV_RECHG_BIT     = 0;

	// Clamp ceilings and special codes
	localparam logic [5:0] CCV_FAST_MAX      = 6'h32;
	localparam logic [3:0] CCV_PRE_MAX       = 4'hc;
	localparam logic [4:0] CCV_VOLT_MAX      = 5'h18;
	localparam logic [4:0] CCV_VOLT_SPECIAL  = 5'h0f;
	localparam logic [3:0] CCV_PRE_POR       = 4'h2;

	// Step values in mA and mV
	localparam int CCV_CUR_STEP_MA    = 60;
	localparam int CCV_CUR_OFFSET_MA  = 60;
	localparam int CCV_VOLT_STEP_MV   = 32;
	localparam int CCV_VOLT_OFFSET_MV = 3856;
	localparam int CCV_VOLT_SPEC_MV   = 4352;
	localparam int CCV_BOOST_LO_MA    = 500;
	localparam int CCV_BOOST_HI_MA    = 1200;
	localparam int CCV_SW_THRESH_MA   = 700;
	localparam int CCV_RECHG_LO_MV    = 100;
	localparam int CCV_RECHG_HI_MV    = 200;

	// Top-off timer
	localparam int CCV_TOP_STEP_MIN = 15;
	localparam int CCV_CLK_MHZ      = 250;
	localparam longint CCV_CYC_PER_MIN = 64'd60 * 64'd1000000 * CCV_CLK_MHZ;

	// Top-off states
	typedef enum logic [1:0] {
		CCV_TOP_IDLE,
		CCV_TOP_EXTEND,
		CCV_TOP_DONE
	} ccv_top_state_t;

endpackage : ccv_pkg

// file: src/ccv_top_timer.sv
// Post-termination extension timer for the charger.
// Assumes termination detection is synchronous to clock_i.
`timescale 1ns/1ns
`default_nettype none
module ccv_top_timer
	import ccv_pkg::*;
#(
	parameter longint CYC_PER_MIN = CCV_CYC_PER_MIN // Cycles in one minute
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// Control
	input  wire logic       charge_active_i,
	input  wire logic       term_met_i,
	input  wire logic [1:0] sel_i,
	// Result
	output logic            charge_done_o
);
	initial begin
		if (CYC_PER_MIN < 1)
			$error("CYC_PER_MIN must be at least one");
	end

	ccv_top_state_t state_r;                // Extension state
	ccv_top_state_t state_nxt;              // Next state
	logic [47:0]    cnt_r;                  // Cycle counter
	logic [47:0]    limit;                  // Cycles of extension
	logic [47:0]    cnt_nxt;                // Next count
	logic           done_nxt;               // Next done flag

	// Extension length from the selection
	assign limit = 48'(CYC_PER_MIN * CCV_TOP_STEP_MIN) * {46'h0, sel_i};

	// Next state, leaving charge clears everything
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		done_nxt  = charge_done_o;
		case (state_r)
			CCV_TOP_IDLE: begin
				cnt_nxt  = 48'h0;
				done_nxt = 1'b0;
				if (charge_active_i && term_met_i) begin
					if (sel_i == 2'h0) begin
						state_nxt = CCV_TOP_DONE;
						done_nxt  = 1'b1;
					end else begin
						state_nxt = CCV_TOP_EXTEND;
					end
				end
			end
			CCV_TOP_EXTEND: begin
				cnt_nxt = cnt_r + 48'h1;
				if (cnt_r + 48'h1 >= limit) begin
					state_nxt = CCV_TOP_DONE;
					done_nxt  = 1'b1;
				end
			end
			CCV_TOP_DONE: begin
				done_nxt = 1'b1;
			end
			default: begin
				state_nxt = CCV_TOP_IDLE;
			end
		endcase
		if (!charge_active_i) begin
			state_nxt = CCV_TOP_IDLE;
			done_nxt  = 1'b0;
			cnt_nxt   = 48'h0;
		end
	end

	// State registers
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			state_r       <= CCV_TOP_IDLE;
			cnt_r         <= 48'h0;
			charge_done_o <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			cnt_r         <= cnt_nxt;
			charge_done_o <= done_nxt;
		end
	end
endmodule : ccv_top_timer
`default_nettype wire

// file: src/ccv_config_bank.sv
// Charger current and voltage configuration registers with decoded outputs.
// Assumes the serial target logic presents byte writes and reads on clock_i.
//
// Contract
// - Boost limit bit: 0.5 A clear, 1.2 A set
// - Full-on clear: high-resistance switch below 700 mA
// - Boost mode always uses full switch
// - Fast charge six bits, 60 mA steps
// - Fast charge code zero disables charging
// - Fast charge codes above 110010 clamp
// - Precharge and termination: 60 mA step, offset
// - Precharge clamps to code 1100
// - Charge voltage 32 mV steps from 3.856 V
// - Voltage resets 01011; code 01111 special 4.352 V
// - Voltage codes above 11000 clamp
// - Top-off code: off, 15, 30, 45 minutes
// - Enabled top-off extends charge after termination
// - Disabled top-off ends charge at termination
// - Host reaches bank at serial address 6BH
`timescale 1ns/1ns
`default_nettype none
module ccv_config_bank
	import ccv_pkg::*;
#(
	parameter longint CYC_PER_MIN = CCV_CYC_PER_MIN // Cycles per minute
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	// Byte register port from the serial target
	input  wire logic [6:0]  target_addr_i,
	input  wire logic        wr_en_i,
	input  wire logic        rd_en_i,
	input  wire logic [7:0]  reg_idx_i,
	input  wire logic [7:0]  wr_data_i,
	output logic [7:0]       rd_data_o,
	output logic             rd_valid_o,
	// Reset sources
	input  wire logic        reg_reset_i,
	input  wire logic        watchdog_expired_i,
	// Charger state
	input  wire logic        boost_mode_i,
	input  wire logic [11:0] input_current_limit_i,
	input  wire logic        charge_request_i,
	input  wire logic        term_met_i,
	// Decoded settings
	output logic [10:0]      boost_current_limit_o,
	output logic             input_switch_full_o,
	output logic [11:0]      fast_charge_current_o,
	output logic             charge_enable_o,
	output logic [9:0]       precharge_current_o,
	output logic [9:0]       termination_current_o,
	output logic [12:0]      charge_voltage_target_o,
	output logic [1:0]       post_termination_extension_o,
	output logic [7:0]       recharge_threshold_o,
	output logic             charge_done_o
);
	initial begin
		if (CYC_PER_MIN < 1)
			$error("CYC_PER_MIN must be at least one");
	end

	// Current from a four-bit code with offset
	function automatic logic [9:0] cur4(input logic [3:0] code);
		cur4 = 10'(CCV_CUR_OFFSET_MA) + 10'(CCV_CUR_STEP_MA) * {6'h0, code};
	endfunction

	logic [7:0] boost_fast_r;               // Boost limit, full-on, fast charge
	logic [7:0] pre_term_r;                 // Precharge and termination
	logic [7:0] volt_top_r;                 // Voltage, top-off, recharge
	logic [7:0] boost_fast_nxt;             // Next value
	logic [7:0] pre_term_nxt;               // Next value
	logic [7:0] volt_top_nxt;               // Next value

	// Address and strobe decode
	wire addr_hit = (target_addr_i == CCV_TARGET_ADDR);
	wire wr_bf    = wr_en_i && addr_hit && (reg_idx_i == CCV_IDX_BOOST_FAST);
	wire wr_pt    = wr_en_i && addr_hit && (reg_idx_i == CCV_IDX_PRE_TERM);
	wire wr_vt    = wr_en_i && addr_hit && (reg_idx_i == CCV_IDX_VOLT_TOP);

	// Clamped incoming fields
	wire [5:0] wr_fast = wr_data_i[CCV_FAST_LSB +: 6];
	wire [3:0] wr_pre  = wr_data_i[CCV_PRE_LSB +: 4];
	wire [4:0] wr_volt = wr_data_i[CCV_VOLT_LSB +: 5];
	wire [5:0] cl_fast = (wr_fast > CCV_FAST_MAX) ? CCV_FAST_MAX : wr_fast;
	wire [3:0] cl_pre  = (wr_pre > CCV_PRE_MAX) ? CCV_PRE_MAX : wr_pre;
	wire [4:0] cl_volt = (wr_volt > CCV_VOLT_MAX) ? CCV_VOLT_MAX : wr_volt;

	// Next register values; register reset beats watchdog beats write
	always_comb begin
		boost_fast_nxt = boost_fast_r;
		pre_term_nxt   = pre_term_r;
		volt_top_nxt   = volt_top_r;
		if (wr_bf) begin
			boost_fast_nxt = {wr_data_i[CCV_BOOST_CURRENT_LIMIT_BIT], wr_data_i[CCV_FULL_ON_BIT], cl_fast};
		end
		if (wr_pt) begin
			pre_term_nxt = {cl_pre, wr_data_i[CCV_TERM_LSB +: 4]};
		end
		if (wr_vt) begin
			volt_top_nxt = {cl_volt, wr_data_i[CCV_TOP_LSB +: 2], wr_data_i[CCV_RECHG_BIT]};
		end
		if (watchdog_expired_i) begin
			// Full-on bit survives a watchdog expiry
			boost_fast_nxt = {CCV_POR_BOOST_FAST[7], boost_fast_r[CCV_FULL_ON_BIT],
				CCV_POR_BOOST_FAST[5:0]};
			pre_term_nxt   = CCV_POR_PRE_TERM;
			volt_top_nxt   = CCV_POR_VOLT_TOP;
		end
		if (reg_reset_i) begin
			boost_fast_nxt = CCV_POR_BOOST_FAST;
			pre_term_nxt   = CCV_POR_PRE_TERM;
			volt_top_nxt   = CCV_POR_VOLT_TOP;
		end
	end

	// Register storage, power-on values at reset
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			boost_fast_r <= CCV_POR_BOOST_FAST;
			pre_term_r   <= CCV_POR_PRE_TERM;
			volt_top_r   <= CCV_POR_VOLT_TOP;
		end else begin
			boost_fast_r <= boost_fast_nxt;
			pre_term_r   <= pre_term_nxt;
			volt_top_r   <= volt_top_nxt;
		end
	end

	// Read mux; unmapped index reads zero
	wire       rd_hit = rd_en_i && addr_hit;
	wire [7:0] rd_mux = (reg_idx_i == CCV_IDX_BOOST_FAST) ? boost_fast_r :
	                    (reg_idx_i == CCV_IDX_PRE_TERM)   ? pre_term_r   :
	                    (reg_idx_i == CCV_IDX_VOLT_TOP)   ? volt_top_r   : 8'h00;

	// Field decode
	wire [5:0] fast_code = boost_fast_r[CCV_FAST_LSB +: 6];
	wire [3:0] pre_code  = pre_term_r[CCV_PRE_LSB +: 4];
	wire [3:0] term_code = pre_term_r[CCV_TERM_LSB +: 4];
	wire [4:0] volt_code = volt_top_r[CCV_VOLT_LSB +: 5];
	wire [1:0] top_code  = volt_top_r[CCV_TOP_LSB +: 2];

	wire [10:0] boost_ma = boost_fast_r[CCV_BOOST_CURRENT_LIMIT_BIT] ? 11'(CCV_BOOST_HI_MA)
	                                                       : 11'(CCV_BOOST_LO_MA);
	// Low-resistance switch in boost, when forced, or at high input limits
	wire full_sw = boost_mode_i
	             || boost_fast_r[CCV_FULL_ON_BIT]
	             || (input_current_limit_i >= 12'(CCV_SW_THRESH_MA));
	wire [11:0] fast_ma  = 12'(CCV_CUR_STEP_MA) * {6'h0, fast_code};
	wire        chg_en   = charge_request_i && (fast_code != 6'h00);
	wire [12:0] volt_mv  = (volt_code == CCV_VOLT_SPECIAL) ? 13'(CCV_VOLT_SPEC_MV)
	                     : 13'(CCV_VOLT_OFFSET_MV) + 13'(CCV_VOLT_STEP_MV) * {8'h0, volt_code};
	wire [7:0]  rechg_mv = volt_top_r[CCV_RECHG_BIT] ? 8'(CCV_RECHG_HI_MV)
	                                                 : 8'(CCV_RECHG_LO_MV);
	logic       done_w;                     // Extension finished

	// Top-off sequencing
	ccv_top_timer #(
		.CYC_PER_MIN (CYC_PER_MIN)
	) ccv_top_timer_inst (
		.clock_i         (clock_i),
		.reset_i         (reset_i),
		.charge_active_i (chg_en),
		.term_met_i      (term_met_i),
		.sel_i           (top_code),
		.charge_done_o   (done_w)
	);

	// Output registers; all outputs come from flops
	always_ff @(posedge clock_i or posedge reset_i) begin
		if (reset_i) begin
			rd_data_o                    <= 8'h00;
			rd_valid_o                   <= 1'b0;
			boost_current_limit_o        <= 11'h0;
			input_switch_full_o          <= 1'b0;
			fast_charge_current_o        <= 12'h0;
			charge_enable_o              <= 1'b0;
			precharge_current_o          <= 10'h0;
			termination_current_o        <= 10'h0;
			charge_voltage_target_o      <= 13'h0;
			post_termination_extension_o <= 2'h0;
			recharge_threshold_o         <= 8'h0;
			charge_done_o                <= 1'b0;
		end else begin
			rd_data_o                    <= rd_hit ? rd_mux : 8'h00;
			rd_valid_o                   <= rd_hit;
			boost_current_limit_o        <= boost_ma;
			input_switch_full_o          <= full_sw;
			fast_charge_current_o        <= fast_ma;
			charge_enable_o              <= chg_en && !done_w;
			precharge_current_o          <= cur4(pre_code);
			termination_current_o        <= cur4(term_code);
			charge_voltage_target_o      <= volt_mv;
			post_termination_extension_o <= top_code;
			recharge_threshold_o         <= rechg_mv;
			charge_done_o                <= done_w;
		end
	end
endmodule : ccv_config_bank
`default_nettype wire

// file: verification/ccv_config_bank_sva.sv
// Port checker for the charger configuration bank.
// Assumes one clock, reset_i asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none
module ccv_config_bank_sva (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        reset_i,
	// Register port
	input wire logic [6:0]  target_addr_i,
	input wire logic        rd_en_i,
	input wire logic [7:0]  rd_data_o,
	input wire logic        rd_valid_o,
	// Charger state and decoded settings
	input wire logic        boost_mode_i,
	input wire logic [10:0] boost_current_limit_o,
	input wire logic        input_switch_full_o,
	input wire logic [11:0] fast_charge_current_o,
	input wire logic        charge_enable_o,
	input wire logic [9:0]  precharge_current_o,
	input wire logic [12:0] charge_voltage_target_o,
	input wire logic [7:0]  recharge_threshold_o,
	input wire logic        charge_done_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Read to our address answers next cycle
	a_read_gets_valid: assert property (rd_en_i && target_addr_i == 7'h6b |=> rd_valid_o)
		else $error("read not answered");
	// Foreign address or no read: no answer
	a_foreign_no_valid: assert property (!(rd_en_i && target_addr_i == 7'h6b) |=> !rd_valid_o)
		else $error("unexpected read answer");
	// Idle read bus parks at zero
	a_idle_data_zero: assert property (!rd_valid_o |-> rd_data_o == 8'h00)
		else $error("read data not parked");
	// Three cycles allow for either pipeline depth
	a_boost_full_switch: assert property (boost_mode_i [*3] |=> input_switch_full_o)
		else $error("boost without full switch");
	// Decoded values checked once out of reset
	a_boost_two_values: assert property (!$past(reset_i) |-> boost_current_limit_o inside {11'd500, 11'd1200})
		else $error("boost limit value");
	a_fast_clamped: assert property (fast_charge_current_o <= 12'd3000)
		else $error("fast charge above ceiling");
	a_pre_in_range: assert property (!$past(reset_i) |-> precharge_current_o inside {[10'd60:10'd780]})
		else $error("precharge out of range");
	a_volt_in_range: assert property (!$past(reset_i) |-> charge_voltage_target_o inside {[13'd3856:13'd4624]})
		else $error("voltage out of range");
	a_rechg_two_values: assert property (!$past(reset_i) |-> recharge_threshold_o inside {8'd100, 8'd200})
		else $error("recharge threshold value");
	a_done_stops_charge: assert property (charge_done_o |-> !charge_enable_o)
		else $error("charging after done");
endmodule // ccv_config_bank_sva
bind ccv_config_bank ccv_config_bank_sva ccv_config_bank_sva_inst (.*);
`default_nettype wire

// file: verification/ccv_host.sv
// Host model: drives the byte register port on falling edges.
// Assumes the bank takes strobes on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module ccv_host (
	// Clock
	input  wire logic       clock_i,
	// Register port
	output logic      [6:0] target_addr_o,
	output logic            wr_en_o,
	output logic            rd_en_o,
	output logic      [7:0] reg_idx_o,
	output logic      [7:0] wr_data_o,
	input  wire logic [7:0] rd_data_i,
	input  wire logic       rd_valid_i
);
	// Idle bus at time zero
	initial begin
		target_addr_o = 7'h00;
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		reg_idx_o = 8'h00;
		wr_data_o = 8'h00;
	end
	// One write strobe, held across one rising edge
	task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d);
		@(negedge clock_i);
		target_addr_o = a;
		reg_idx_o = i;
		wr_data_o = d;
		wr_en_o = 1'b1;
		@(negedge clock_i);
		wr_en_o = 1'b0;
		// Released data must not look valid
		wr_data_o = ~d;
	endtask
	// One read strobe; answer is settled one edge later
	task automatic rd(input logic [6:0] a, input logic [7:0] i, output logic [7:0] d, output logic v);
		@(negedge clock_i);
		target_addr_o = a;
		reg_idx_o = i;
		rd_en_o = 1'b1;
		@(negedge clock_i);
		rd_en_o = 1'b0;
		d = rd_data_i;
		v = rd_valid_i;
	endtask
endmodule // ccv_host
`default_nettype wire

// file: verification/charger_current_voltage_config_test.sv
// Self-checking bench for the charger configuration bank.
// Assumes a one-minute count shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module charger_current_voltage_config_test;
	import ccv_pkg::*;
	logic clock_i, reset_i, reg_reset_i, watchdog_expired_i, boost_mode_i, charge_request_i, term_met_i;
	logic [11:0] input_current_limit_i;
	logic [6:0]  ta;
	logic        we, re, rv, vs, cen, cdn, sw;
	logic [7:0]  ix, wd, rdat, d, rch;
	logic [10:0] bl;
	logic [11:0] fc;
	logic [9:0]  pc, tc;
	logic [12:0] cv;
	logic [1:0]  ext;
	int n_errors = 0, checks = 0, cyc = 0;
	ccv_config_bank #(.CYC_PER_MIN(10)) ccv_config_bank_inst (.clock_i, .reset_i, .target_addr_i(ta), .wr_en_i(we),
		.rd_en_i(re), .reg_idx_i(ix), .wr_data_i(wd), .rd_data_o(rdat), .rd_valid_o(rv), .reg_reset_i,
		.watchdog_expired_i, .boost_mode_i, .input_current_limit_i, .charge_request_i, .term_met_i,
		.boost_current_limit_o(bl), .input_switch_full_o(sw), .fast_charge_current_o(fc), .charge_enable_o(cen),
		.precharge_current_o(pc), .termination_current_o(tc), .charge_voltage_target_o(cv),
		.post_termination_extension_o(ext), .recharge_threshold_o(rch), .charge_done_o(cdn));
	ccv_host ccv_host_inst (.clock_i, .target_addr_o(ta), .wr_en_o(we), .rd_en_o(re), .reg_idx_o(ix),
		.wr_data_o(wd), .rd_data_i(rdat), .rd_valid_i(rv));
	// Clock and hang guard
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Read back one register of our address
	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		ccv_host_inst.rd(7'h6b, i, d, vs);
		chk("valid", vs, 16'h1);
		chk("reg", d, e);
	endtask
	// Write then let the decode settle
	task automatic wrs(input logic [7:0] i, input logic [7:0] v);
		ccv_host_inst.wr(7'h6b, i, v);
		repeat (2) @(negedge clock_i);
	endtask
	task automatic close_out();
		if (n_errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		{reset_i, reg_reset_i, watchdog_expired_i, boost_mode_i, charge_request_i, term_met_i} = 6'b100000;
		input_current_limit_i = 12'd600;
		repeat (8) @(negedge clock_i);
		reset_i = 1'b0;
		repeat (2) @(negedge clock_i);
		rdc(8'h02, 8'ha2);
		rdc(8'h03, 8'h22);
		rdc(8'h04, 8'h58);
		chk("boost", bl, 16'd1200);
		chk("fast", fc, 16'd2040);
		chk("pre", pc, 16'd180);
		chk("term", tc, 16'd180);
		chk("volt", cv, 16'd4208);
		chk("rechg", rch, 16'd100);
		chk("switch", sw, 16'h0);
		// Over-range codes, back to back
		ccv_host_inst.wr(7'h6b, 8'h02, 8'hff);
		ccv_host_inst.wr(7'h6b, 8'h03, 8'hff);
		wrs(8'h04, 8'hff);
		rdc(8'h02, 8'hf2);
		rdc(8'h03, 8'hcf);
		rdc(8'h04, 8'hc7);
		chk("fast", fc, 16'd3000);
		chk("switch", sw, 16'h1);
		chk("pre", pc, 16'd780);
		chk("term", tc, 16'd960);
		chk("volt", cv, 16'd4624);
		chk("rechg", rch, 16'd200);
		for (int k = 0; k < 4; k++) begin
			wrs(8'h04, 8'h78 | 8'(k << 1));
			chk("volt", cv, 16'd4352);
			chk("ext", ext, 16'(k));
		end
		wrs(8'h02, 8'h00);
		chk("boost", bl, 16'd500);
		chk("fast", fc, 16'd0);
		charge_request_i = 1'b1;
		repeat (3) @(negedge clock_i);
		chk("enable", cen, 16'h0);
		chk("switch", sw, 16'h0);
		input_current_limit_i = 12'd700;
		repeat (3) @(negedge clock_i);
		chk("switch", sw, 16'h1);
		input_current_limit_i = 12'd600;
		boost_mode_i = 1'b1;
		repeat (4) @(negedge clock_i);
		chk("switch", sw, 16'h1);
		boost_mode_i = 1'b0;
		// Foreign address and unmapped index
		ccv_host_inst.wr(7'h6a, 8'h02, 8'h44);
		ccv_host_inst.rd(7'h6a, 8'h02, d, vs);
		chk("valid", vs, 16'h0);
		rdc(8'h02, 8'h00);
		rdc(8'h05, 8'h00);
		// Watchdog keeps full-on bit, register reset does not
		wrs(8'h02, 8'h41);
		watchdog_expired_i = 1'b1;
		@(negedge clock_i);
		watchdog_expired_i = 1'b0;
		rdc(8'h02, 8'he2);
		reg_reset_i = 1'b1;
		@(negedge clock_i);
		reg_reset_i = 1'b0;
		rdc(8'h02, 8'ha2);
		// Top-off off: done at termination
		repeat (3) @(negedge clock_i);
		chk("enable", cen, 16'h1);
		term_met_i = 1'b1;
		repeat (4) @(negedge clock_i);
		chk("done", cdn, 16'h1);
		chk("enable", cen, 16'h0);
		{term_met_i, charge_request_i} = 2'b00;
		wrs(8'h04, 8'h5a);
		charge_request_i = 1'b1;
		repeat (3) @(negedge clock_i);
		chk("done", cdn, 16'h0);
		// Fifteen minutes of ten cycles each
		term_met_i = 1'b1;
		repeat (140) @(negedge clock_i);
		chk("enable", cen, 16'h1);
		repeat (20) @(negedge clock_i);
		chk("done", cdn, 16'h1);
		close_out();
	end
endmodule // charger_current_voltage_config_test
`default_nettype wire
